// ---- include/acs_regs.svh ----
// register offsets, field positions, reset values and command codes of the calibration sequencer
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

`define ACS_OFF_LAUNCH 8'h03
`define ACS_OFF_STATUS 8'h04
`define ACS_OFF_RATE 8'h08
`define ACS_OFF_AMP 8'h0e
`define ACS_OFF_CLKFMT 8'h11
`define ACS_OFF_SELF_ZERO 8'h30
`define ACS_OFF_SELF_GAIN0 8'h31
`define ACS_OFF_SYS_ZERO0 8'h39
`define ACS_OFF_SYS_SCALE0 8'h3b

`define ACS_RST_CONFIG 8'h00
`define ACS_OFFSET_ZERO 24'h000000
`define ACS_GAIN_UNITY 24'h800000
`define ACS_GAIN_MIN 24'h400000
`define ACS_FULL_SCALE_X2 24'hfffffe

`define ACS_FMT_BIT 0
`define ACS_SYSSEL_LSB 4
`define ACS_GAIN_LSB 0

`define ACS_CMD_SELF 3'h0
`define ACS_CMD_GAIN 3'h1
`define ACS_CMD_ZERO_A 3'h4
`define ACS_CMD_SCALE_A 3'h5
`define ACS_CMD_ZERO_B 3'h6
`define ACS_CMD_SCALE_B 3'h7

`define ACS_SRC_PINS 2'h0
`define ACS_SRC_ZERO 2'h1
`define ACS_SRC_FULL 2'h2

`endif

// ---- include/acs_pkg.sv ----
// types shared by the calibration sequencer
package acs_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_CAL_WAIT, ST_DIVIDE, ST_RUN_WAIT} acs_state_t;
    typedef enum logic [1:0] {CAL_SELF, CAL_GAIN, CAL_SYS_ZERO, CAL_SYS_SCALE} acs_cal_kind_t;
endpackage

// ---- design/acs_cal_divider.sv ----
// sequential divider that turns a measured full scale into a gain coefficient
module acs_cal_divider #(
    parameter int W = 24
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request
    input wire logic start,
    input wire logic [2*W-1:0] dividend,
    input wire logic [W-1:0] divisor,
    // answer
    output logic done,
    output logic [W-1:0] quotient
);
    localparam logic [2*W-1:0] QMAX = {{W{1'b0}}, {W{1'b1}}};
    localparam logic [2*W-1:0] QMIN = (2*W)'({2'b01, {(W-2){1'b0}}});

    logic [W:0] rem;
    logic [2*W-1:0] quo;
    logic [$clog2(2*W+1)-1:0] cnt;
    logic running;
    wire logic [W:0] shifted = {rem[W-1:0], quo[2*W-1]};
    wire logic fits = shifted >= {1'b0, divisor};
    // a zero divisor always fits: all ones, clamped to the maximum
    wire logic [2*W-1:0] nextQuo = {quo[2*W-2:0], fits};
    wire logic [W-1:0] clamped = (nextQuo > QMAX) ? W'(QMAX) :
                                 (nextQuo < QMIN) ? W'(QMIN) : nextQuo[W-1:0]; // R12

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rem <= '0;
            quo <= '0;
            cnt <= '0;
            running <= 1'b0;
            done <= 1'b0;
            quotient <= '0;
        end
        else if (start)
        begin
            rem <= '0;
            quo <= dividend;
            cnt <= '0;
            running <= 1'b1;
            done <= 1'b0;
        end
        else if (running)
        begin
            rem <= fits ? (shifted - {1'b0, divisor}) : shifted;
            quo <= nextQuo;
            cnt <= cnt + 1'b1;
            if (cnt == ($bits(cnt))'(2*W-1))
            begin
                running <= 1'b0;
                done <= 1'b1;
                quotient <= clamped;
            end
        end
        else
        begin
            done <= 1'b0;
        end
    end
endmodule // acs_cal_divider

// ---- design/acs_cal_sequencer.sv ----
// calibration sequencer: coefficient registers, calibration runs and result correction
// Behaviour
// R1: eight internal gain registers, one per gain
// R2: gain calibration updates only selected gain's register
// R3: code 000: two conversions, offset and unity gain
// R4: code 001: one conversion, selected gain register
// R5: selected gain's stored correction applied to conversions
// R6: host calibrates every gain it will use
// R7: zero-scale input, then command stores system offset
// R8: full-scale input, then command stores system gain
// R9: two system sets; apply A, B or neither
// R10: every coefficient register host writable
// R11: offset step half LSB, range quarter reference
// R12: gain correction between one half and two
// R13: host runs system offset before system gain
// R14: host routes multiplexer before system calibration
// R15: calibration runs at programmed rate and filter
// R16: external clock running before any calibration
// R17: calibration results independent of output format
// R18: host recalibrates when operating conditions change
// R19: codes 100 and 110: system offset A, B
// R20: codes 101 and 111: system gain A, B
// R21: result equals system gain times corrected difference
// R22: offsets reset to zero, gains to unity
// R23: busy until update; conversion requests then ignored
`include "acs_regs.svh"

module acs_cal_sequencer (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [23:0] regWrData,
    output logic [23:0] regRdData,
    // configuration seen by the filter and amplifier
    output logic [7:0] rateSelect,
    output logic [7:0] ampGainPath,
    output logic [7:0] clockFormatConfig,
    // conversion engine
    input wire logic convReq,
    output logic convStart,
    output logic [1:0] calInputSel,
    input wire logic convDone,
    input wire logic [23:0] convRaw,
    // results and status
    output logic [23:0] dataOut,
    output logic dataValid,
    output logic calBusy
);
    acs_pkg::acs_state_t state;
    acs_pkg::acs_cal_kind_t calKind;
    logic calSet;
    logic calPhase;
    logic [2:0] calGain;
    logic [7:0] calLaunch;
    logic [23:0] selfOffset;
    logic [23:0] selfGain [8];
    logic [23:0] sysZero [2];
    logic [23:0] sysScale [2];
    logic [23:0] divisor;
    logic divStart;
    logic divDone;
    logic [23:0] divQuot;

    function automatic logic [23:0] sat24(input logic signed [30:0] v);
        if (v > 31'sh007fffff)
            return 24'h7fffff;
        else if (v < -31'sh00800000)
            return 24'h800000;
        else
            return v[23:0];
    endfunction

    function automatic logic [23:0] posClamp(input logic signed [28:0] v);
        if (v <= 29'sh0)
            return 24'h000000;
        else if (v > 29'sh0ffffff)
            return 24'hffffff;
        else
            return v[23:0];
    endfunction

    // command decode
    wire logic hostWr = regWrEn;
    wire logic [2:0] cmdCode = regWrData[2:0];
    wire logic launchWr = hostWr && (regAddr == `ACS_OFF_LAUNCH);
    wire logic cmdValid = (cmdCode == `ACS_CMD_SELF) || (cmdCode == `ACS_CMD_GAIN) ||
                          cmdCode[2];
    wire logic isIdle = (state == acs_pkg::ST_IDLE);
    wire logic launchGo = launchWr && cmdValid && isIdle;
    wire acs_pkg::acs_cal_kind_t cmdKind =
        (cmdCode == `ACS_CMD_SELF) ? acs_pkg::CAL_SELF : // R3
        (cmdCode == `ACS_CMD_GAIN) ? acs_pkg::CAL_GAIN : // R4
        (cmdCode[0] == 1'b0) ? acs_pkg::CAL_SYS_ZERO : // R19
        acs_pkg::CAL_SYS_SCALE; // R20
    wire logic cmdSet = cmdCode[1];
    wire logic [2:0] liveGain = ampGainPath[`ACS_GAIN_LSB +: 3];

    // correction path: system gain x (((raw - self offset) x self gain) - system offset)
    wire logic calRun = (state != acs_pkg::ST_IDLE) && (state != acs_pkg::ST_RUN_WAIT);
    wire logic [2:0] useGain = calRun ? calGain : liveGain;                 // R5
    wire logic [1:0] sysSel = clockFormatConfig[`ACS_SYSSEL_LSB +: 2];
    wire logic sysCal = (calKind == acs_pkg::CAL_SYS_SCALE);
    wire logic applySys = (calRun && sysCal) || (!calRun && (sysSel == 2'h1 || sysSel == 2'h2));
    wire logic useSet = (calRun && sysCal) ? calSet : (sysSel == 2'h2);     // R9
    wire logic [23:0] sysZeroUsed = applySys ? sysZero[useSet] : `ACS_OFFSET_ZERO;
    wire logic [23:0] sysScaleUsed = (applySys && !calRun) ? sysScale[useSet] : `ACS_GAIN_UNITY;
    // offsets are kept in half-LSB steps, so the raw code is doubled before subtracting
    wire logic signed [25:0] rawX2 = {convRaw[23], convRaw, 1'b0};          // R11
    wire logic signed [25:0] selfOffX = {{2{selfOffset[23]}}, selfOffset};
    wire logic signed [25:0] diff1 = rawX2 - selfOffX;                      // R21
    wire logic signed [24:0] gain1 = {1'b0, selfGain[useGain]};
    wire logic signed [50:0] prod1 = diff1 * gain1;
    wire logic signed [27:0] stage1 = prod1[50:23];
    wire logic signed [28:0] sysOffX = {{5{sysZeroUsed[23]}}, sysZeroUsed};
    wire logic signed [28:0] diff2 = {stage1[27], stage1} - sysOffX;       // R21
    wire logic signed [24:0] gain2 = {1'b0, sysScaleUsed};
    wire logic signed [53:0] prod2 = diff2 * gain2;
    wire logic signed [30:0] stage2 = prod2[53:23];
    wire logic [23:0] corrected = sat24({stage2[30], stage2[30:1]});
    // format only touches the delivered result, never a stored coefficient
    wire logic [23:0] formatted = clockFormatConfig[`ACS_FMT_BIT] ?
                                  {~corrected[23], corrected[22:0]} : corrected; // R17

    // calibration arithmetic
    wire logic selfFirst = (calKind == acs_pkg::CAL_SELF) && !calPhase;
    wire logic calDone = (state == acs_pkg::ST_CAL_WAIT) && convDone;
    wire logic zeroDone = calDone && (calKind == acs_pkg::CAL_SYS_ZERO);
    wire logic needDiv = calDone && !selfFirst && !zeroDone;
    wire logic [23:0] next_divisor = sysCal ? posClamp(diff2) :
                                    posClamp({{3{diff1[25]}}, diff1});
    wire logic [47:0] fullScaleNum = {1'b0, `ACS_FULL_SCALE_X2, 23'h0};
    wire logic [23:0] selfZeroNew = sat24({{5{rawX2[25]}}, rawX2});         // R11
    wire logic [23:0] sysZeroNew = sat24({{3{stage1[27]}}, stage1});        // R7
    wire logic hwSelfZero = calDone && selfFirst; // R3

    acs_cal_divider #(
        .W(24)
    ) u_divider (
        .clk(clk),
        .rst_n(rst_n),
        .start(divStart),
        .dividend(fullScaleNum),
        .divisor(divisor),
        .done(divDone),
        .quotient(divQuot)
    );

    // sequencing
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state <= acs_pkg::ST_IDLE;
            calKind <= acs_pkg::CAL_SELF;
            calSet <= 1'b0;
            calPhase <= 1'b0;
            calGain <= 3'h0;
            convStart <= 1'b0;
            calInputSel <= `ACS_SRC_PINS;
            divStart <= 1'b0;
            divisor <= 24'h0;
            dataOut <= 24'h0;
            dataValid <= 1'b0;
        end
        else
        begin
            convStart <= 1'b0;
            divStart <= 1'b0;
            dataValid <= 1'b0;
            case (state)
                acs_pkg::ST_IDLE:
                begin
                    if (launchGo)
                    begin
                        // rate and filter are live registers, so the run uses them as set
                        calKind <= cmdKind;                                 // R15
                        calSet <= cmdSet;
                        calPhase <= 1'b0;
                        calGain <= liveGain;                                // R2
                        convStart <= 1'b1;
                        calInputSel <= (cmdKind == acs_pkg::CAL_SELF) ? `ACS_SRC_ZERO :
                                       (cmdKind == acs_pkg::CAL_GAIN) ? `ACS_SRC_FULL :
                                       `ACS_SRC_PINS;                       // R7 R8
                        state <= acs_pkg::ST_CAL_WAIT;
                    end
                    else if (convReq)
                    begin
                        convStart <= 1'b1;
                        calInputSel <= `ACS_SRC_PINS;
                        state <= acs_pkg::ST_RUN_WAIT;
                    end
                end
                acs_pkg::ST_CAL_WAIT:
                begin
                    if (hwSelfZero)
                    begin
                        // second self conversion looks at the internal full scale
                        calPhase <= 1'b1;                                   // R3
                        convStart <= 1'b1;
                        calInputSel <= `ACS_SRC_FULL;
                    end
                    else if (zeroDone)
                    begin
                        state <= acs_pkg::ST_IDLE;
                    end
                    else if (needDiv)
                    begin
                        divisor <= next_divisor;                            // R8
                        divStart <= 1'b1;
                        state <= acs_pkg::ST_DIVIDE;
                    end
                end
                acs_pkg::ST_DIVIDE:
                begin
                    if (divDone)
                    begin
                        state <= acs_pkg::ST_IDLE;
                    end
                end
                acs_pkg::ST_RUN_WAIT:
                begin
                    if (convDone)
                    begin
                        dataOut <= formatted;                               // R21
                        dataValid <= 1'b1;
                        state <= acs_pkg::ST_IDLE;
                    end
                end
                default:
                begin
                    state <= acs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // busy from the launch write until the coefficient lands; requests meanwhile are dropped
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            calBusy <= 1'b0;
        else
            calBusy <= launchGo || (calRun && !zeroDone && !divDone);       // R23
    end

    // configuration registers and last launch code
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rateSelect <= `ACS_RST_CONFIG;
            ampGainPath <= `ACS_RST_CONFIG;
            clockFormatConfig <= `ACS_RST_CONFIG;
            calLaunch <= `ACS_RST_CONFIG;
        end
        else if (hostWr)
        begin
            if (regAddr == `ACS_OFF_RATE)
                rateSelect <= regWrData[7:0];
            if (regAddr == `ACS_OFF_AMP)
                ampGainPath <= regWrData[7:0];
            if (regAddr == `ACS_OFF_CLKFMT)
                clockFormatConfig <= regWrData[7:0];
            if (launchWr)
                calLaunch <= regWrData[7:0];
        end
    end

    // internal offset: hardware update wins over a host write in the same cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            selfOffset <= `ACS_OFFSET_ZERO; // R22
        else if (hwSelfZero)
            selfOffset <= selfZeroNew; // R3
        else if (hostWr && regAddr == `ACS_OFF_SELF_ZERO)
            selfOffset <= regWrData; // R10
    end

    // per-gain internal gain registers
    generate
        for (genvar g = 0; g < 8; g++)
        begin : gen_self_gain
            wire logic hwHit = divDone && (((calKind == acs_pkg::CAL_SELF) && (g == 0)) ||
                               ((calKind == acs_pkg::CAL_GAIN) && (calGain == 3'(g)))); // R2
            wire logic hostHit = hostWr && (regAddr == 8'(`ACS_OFF_SELF_GAIN0 + g));
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                    selfGain[g] <= `ACS_GAIN_UNITY; // R1 R22
                else if (hwHit)
                    selfGain[g] <= divQuot; // R4
                else if (hostHit)
                    selfGain[g] <= regWrData; // R10
            end
        end
    endgenerate

    // system coefficient sets A and B
    generate
        for (genvar s = 0; s < 2; s++)
        begin : gen_sys_set
            wire logic zeroHit = zeroDone && (calSet == 1'(s));             // R19
            wire logic scaleHit = divDone && sysCal && (calSet == 1'(s));   // R20
            wire logic hostZero = hostWr && (regAddr == 8'(`ACS_OFF_SYS_ZERO0 + s));
            wire logic hostScale = hostWr && (regAddr == 8'(`ACS_OFF_SYS_SCALE0 + s));
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    sysZero[s] <= `ACS_OFFSET_ZERO;                         // R22
                    sysScale[s] <= `ACS_GAIN_UNITY;
                end
                else
                begin
                    if (zeroHit)
                        sysZero[s] <= sysZeroNew;                           // R7
                    else if (hostZero)
                        sysZero[s] <= regWrData;                            // R10
                    if (scaleHit)
                        sysScale[s] <= divQuot;                             // R8
                    else if (hostScale)
                        sysScale[s] <= regWrData;
                end
            end
        end
    endgenerate

    // read selection
    logic [23:0] rdMux;
    always_comb
    begin
        rdMux = 24'h0;
        case (regAddr)
            `ACS_OFF_LAUNCH: rdMux = {16'h0, calLaunch};
            `ACS_OFF_STATUS: rdMux = {19'h0, calBusy, calKind, calPhase, calSet};
            `ACS_OFF_RATE: rdMux = {16'h0, rateSelect};
            `ACS_OFF_AMP: rdMux = {16'h0, ampGainPath};
            `ACS_OFF_CLKFMT: rdMux = {16'h0, clockFormatConfig};
            `ACS_OFF_SELF_ZERO: rdMux = selfOffset;
            default: rdMux = 24'h0;
        endcase
        for (int i = 0; i < 8; i++)
            if (regAddr == 8'(`ACS_OFF_SELF_GAIN0 + i))
                rdMux = selfGain[i];
        for (int i = 0; i < 2; i++)
        begin
            if (regAddr == 8'(`ACS_OFF_SYS_ZERO0 + i))
                rdMux = sysZero[i];
            if (regAddr == 8'(`ACS_OFF_SYS_SCALE0 + i))
                rdMux = sysScale[i];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            regRdData <= 24'h0;
        else if (regRdEn)
            regRdData <= rdMux;
    end
endmodule // acs_cal_sequencer

// ---- testbench/acs_cal_sequencer_assertions.sv ----
// port checker for the calibration sequencer
`include "acs_regs.svh"

module acs_cal_sequencer_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register writes
    input wire logic regWrEn,
    input wire logic [7:0] regAddr,
    input wire logic [23:0] regWrData,
    // conversion engine and status
    input wire logic convReq,
    input wire logic convStart,
    input wire logic [1:0] calInputSel,
    input wire logic convDone,
    input wire logic dataValid,
    input wire logic calBusy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pend;
    logic [2:0] kind;
    wire logic [2:0] code = regWrData[2:0];
    wire logic launch = regWrEn && regAddr == `ACS_OFF_LAUNCH && code[2:1] != 2'b01;
    // idle only once the result pulse is gone
    wire logic quiet = !calBusy && !pend && !convStart && !dataValid;
    wire logic [1:0] expSel = code == 3'h0 ? 2'h1 : (code == 3'h1 ? 2'h2 : 2'h0);
    wire logic gainKind = kind == 3'h1 || (kind[2] && kind[0]);
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pend <= 1'b0;
        else if (convStart)
            pend <= 1'b1;
        else if (convDone)
            pend <= 1'b0;
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            kind <= 3'h0;
        else if (launch && quiet)
            kind <= code;
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_launch;
        launch && quiet |=> convStart && calBusy && calInputSel == $past(expSel);
    endproperty
    a_launch: assert property (p_launch) else $error("launch did not start");
    property p_normal;
        convReq && quiet && !launch |=> convStart && !calBusy && calInputSel == 2'h0;
    endproperty
    a_normal: assert property (p_normal) else $error("conversion not started");
    property p_busyQuiet;
        calBusy |-> !dataValid;
    endproperty
    a_busyQuiet: assert property (p_busyQuiet) else $error("result during calibration");
    property p_selHold;
        $changed(calInputSel) |-> convStart;
    endproperty
    a_selHold: assert property (p_selHold) else $error("input source moved alone");
    property p_selfSecond;
        calBusy && convDone && kind == 3'h0 && calInputSel == 2'h1 |=> convStart && calInputSel == 2'h2;
    endproperty
    a_selfSecond: assert property (p_selfSecond) else $error("no second conversion");
    property p_zeroEnd;
        calBusy && convDone && kind[2] && !kind[0] |=> !calBusy;
    endproperty
    a_zeroEnd: assert property (p_zeroEnd) else $error("offset run did not end");
    property p_gainEnd;
        calBusy && convDone && gainKind |=> calBusy [*2] ##[1:80] !calBusy;
    endproperty
    a_gainEnd: assert property (p_gainEnd) else $error("gain run length wrong");
    property p_resetQuiet;
        !$past(rst_n) |-> !calBusy && !convStart && !dataValid && calInputSel == 2'h0;
    endproperty
    a_resetQuiet: assert property (p_resetQuiet) else $error("outputs not clear");
    c_self: cover property (launch && quiet && code == 3'h0);
    c_conv: cover property (dataValid);
    c_zero: cover property (calBusy && convDone && kind[2] && !kind[0]);
endmodule // acs_cal_sequencer_assertions

bind acs_cal_sequencer acs_cal_sequencer_assertions u_chk (.clk, .rst_n, .regWrEn, .regAddr,
    .regWrData, .convReq, .convStart, .calInputSel, .convDone, .dataValid, .calBusy);

// ---- testbench/acs_conv_model.sv ----
// behavioural conversion engine facing the sequencer
module acs_conv_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request
    input wire logic convStart,
    input wire logic [1:0] calInputSel,
    // levels per input source
    input wire logic [23:0] pinLevel,
    input wire logic [23:0] zeroLevel,
    input wire logic [23:0] fullLevel,
    // answer
    output logic convDone,
    output logic [23:0] convRaw = 24'h5a5a5a
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    logic [1:0] src;
    always @(posedge clk)
    begin
        convDone <= 1'b0;
        convRaw <= ~convRaw; // data is only good in the done cycle
        if (!rst_n)
            cnt <= 4'h0;
        else if (convStart)
        begin
            cnt <= 4'(2 + $urandom % 8);
            src <= calInputSel;
        end
        else if (cnt == 4'h1)
        begin
            cnt <= 4'h0;
            convDone <= 1'b1;
            convRaw <= src == 2'h1 ? zeroLevel : (src == 2'h2 ? fullLevel : pinLevel);
        end
        else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
    end
endmodule // acs_conv_model

// ---- testbench/acs_cal_sequencer_tb.sv ----
// self-checking bench for the calibration sequencer
`include "acs_regs.svh"

module acs_cal_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic convReq = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [23:0] regWrData = 24'h000000;
    logic [23:0] pinLevel = 24'h000000;
    logic [23:0] fullLevel = 24'h5fffff;
    logic [23:0] regRdData, dataOut, convRaw, d;
    logic [7:0] rateSelect, ampGainPath, clockFormatConfig;
    logic [1:0] calInputSel;
    logic convStart, convDone, dataValid, calBusy;
    int err_count = 0;
    int n_checks = 0;
    int k, s, f;
    longint raw, so;
    longint sg [8];
    longint zo [2];
    longint zg [2];

    always #2 clk = ~clk;

    acs_cal_sequencer dut (.clk, .rst_n, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData,
        .rateSelect, .ampGainPath, .clockFormatConfig, .convReq, .convStart, .calInputSel,
        .convDone, .convRaw, .dataOut, .dataValid, .calBusy);
    acs_conv_model engine (.clk, .rst_n, .convStart, .calInputSel, .pinLevel,
        .zeroLevel(24'h000005), .fullLevel, .convDone, .convRaw);

    task automatic test_done;
        if (err_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [23:0] v);
        regAddr <= a;
        regWrData <= v;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [23:0] exp);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        @(posedge clk);
        chk($sformatf("register %h", a), exp, regRdData);
    endtask
    task automatic waitFor(input bit valid);
        int i;
        for (i = 0; i < 400; i++)
        begin
            @(posedge clk);
            if (valid ? dataValid === 1'b1 : calBusy === 1'b0)
                break;
        end
        if (i == 400)
        begin
            err_count++;
            test_done();
        end
    endtask
    task automatic chkGains;
        for (int i = 0; i < 8; i++)
            rdChk(8'(`ACS_OFF_SELF_GAIN0 + i), 24'(sg[i]));
    endtask
    function automatic logic [23:0] dflt(input int a);
        return (a == 8'h30 || a == 8'h39 || a == 8'h3a) ? 24'h000000 : 24'h800000;
    endfunction
    // floored quotient, clamped to the half-to-two span
    function automatic longint gainOf(input longint m);
        longint q = (m <= 0) ? 64'hffffff : (64'hfffffe << 23) / m;
        return (q > 64'hffffff) ? 64'hffffff : ((q < 64'h400000) ? 64'h400000 : q);
    endfunction
    // positive inputs only: halving matches shifting
    function automatic logic [23:0] resOf(input longint r, input int g, input int set, input bit fmt);
        longint v;
        logic [23:0] o;
        v = ((2 * r - so) * sg[g]) >>> 23;
        if (set == 1 || set == 2)
            v = ((v - zo[set - 1]) * zg[set - 1]) >>> 23;
        o = 24'(v / 2);
        o[23] = o[23] ^ fmt;
        return o;
    endfunction

    initial
    begin
        void'($urandom(32'h9176));
        for (int i = 0; i < 8; i++)
            sg[i] = 64'h800000;
        zo = '{0, 0};
        zg = '{64'h800000, 64'h800000};
        so = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int a = 8'h30; a <= 8'h3c; a++)
        begin
            rdChk(8'(a), dflt(a));
            d = 24'($urandom);
            wr(8'(a), d);
            rdChk(8'(a), d);
            wr(8'(a), dflt(a));
        end
        rdChk(8'h7f, 24'h000000);
        d = 24'($urandom % 256);
        wr(`ACS_OFF_RATE, d);
        chk("rateSelect", d, {16'h0, rateSelect});
        // self cal ignores gain and format
        wr(`ACS_OFF_AMP, 24'h000005);
        wr(`ACS_OFF_CLKFMT, 24'h000001);
        wr(`ACS_OFF_LAUNCH, 24'h0000f8);
        convReq <= 1'b1;
        @(posedge clk);
        convReq <= 1'b0;
        waitFor(1'b0);
        so = 10;
        sg[0] = gainOf(2 * 64'h5fffff - so);
        rdChk(`ACS_OFF_SELF_ZERO, 24'(so));
        chkGains();
        k = 1 + $urandom % 6;
        fullLevel <= 24'h300000;
        wr(`ACS_OFF_AMP, 24'(k));
        wr(`ACS_OFF_LAUNCH, 24'h000051);
        waitFor(1'b0);
        sg[k] = gainOf(2 * 64'h300000 - so);
        chkGains();
        wr(`ACS_OFF_LAUNCH, 24'h000002);
        chk("calBusy", 24'h000000, {23'h0, calBusy});
        wr(`ACS_OFF_SELF_ZERO, 24'h000000);
        so = 0;
        wr(`ACS_OFF_AMP, 24'h000007);
        for (s = 0; s < 2; s++)
        begin
            pinLevel <= 24'(100 + 50 * s);
            wr(`ACS_OFF_LAUNCH, 24'(4 + 2 * s));
            waitFor(1'b0);
            zo[s] = 200 + 100 * s;
            rdChk(8'(`ACS_OFF_SYS_ZERO0 + s), 24'(zo[s]));
            raw = 64'h480000 + 64'h80000 * s;
            pinLevel <= 24'(raw);
            wr(`ACS_OFF_LAUNCH, 24'(5 + 2 * s));
            waitFor(1'b0);
            zg[s] = gainOf(2 * raw - zo[s]);
            rdChk(8'(`ACS_OFF_SYS_SCALE0 + s), 24'(zg[s]));
        end
        repeat (16)
        begin
            k = $urandom % 8;
            s = $urandom % 4;
            f = $urandom % 2;
            raw = 64'h1000 + $urandom % 32'h80000;
            pinLevel <= 24'(raw);
            wr(`ACS_OFF_AMP, 24'(k));
            wr(`ACS_OFF_CLKFMT, 24'(s * 16 + f));
            chk("ampGainPath", 24'(k), {16'h0, ampGainPath});
            chk("clockFormatConfig", 24'(s * 16 + f), {16'h0, clockFormatConfig});
            convReq <= 1'b1;
            @(posedge clk);
            convReq <= 1'b0;
            waitFor(1'b1);
            chk("dataOut", resOf(raw, k, s, f[0]), dataOut);
        end
        test_done();
    end
endmodule // acs_cal_sequencer_tb
